// [pkg/arc_pkg.sv]
// Purpose: Shared constants and types for the converter register control block
// Assumes: APB byte addresses are four times the register index
// Notes: Timing figures are given in their own unit and turned into cycles here

package arc_pkg;

    // Register indices as printed, byte address is index times four
    localparam logic [7:0] ARC_CSR_IDX = 8'h70;
    localparam logic [7:0] ARC_DRH_IDX = 8'h71;
    localparam logic [7:0] ARC_DRL_IDX = 8'h72;
    localparam logic [7:0] ARC_IRQ_STAT_IDX = 8'h73;
    localparam logic [7:0] ARC_IRQ_MASK_IDX = 8'h74;
    localparam logic [7:0] ARC_AUX_IDX = 8'h75;
    localparam int ARC_ADDR_W = 12;

    // Reset values
    localparam logic [7:0] ARC_CSR_RST = 8'h00;
    localparam logic [9:0] ARC_RESULT_RST = 10'h000;

    // Interrupt status and mask layout
    localparam int ARC_IRQ_W = 2;
    localparam int ARC_IRQ_DONE_BIT = 0;
    localparam int ARC_IRQ_ABORT_BIT = 1;
    localparam logic [ARC_IRQ_W-1:0] ARC_IRQ_RST = 2'h0;

    // Converter clock divider terminal counts
    localparam logic [1:0] ARC_DIV_SLOW_TOP = 2'h3;
    localparam logic [1:0] ARC_DIV_FAST_TOP = 2'h1;

    // Converter clock periods per conversion, analog core abstraction
    localparam logic [3:0] ARC_CONV_TICKS = 4'hb;

    // Stabilization after halt wakeup, figure is a plain default
    localparam int ARC_CLK_NS = 50;
    localparam int ARC_STAB_NS = 10000;
    localparam int ARC_STAB_CYCLES = (ARC_STAB_NS + ARC_CLK_NS - 1) / ARC_CLK_NS;
    localparam int ARC_STAB_W = 8;

    // Control and status register fields
    typedef struct packed {
        logic eoc;
        logic speed;
        logic conv_on;
        logic rsvd;
        logic [3:0] channel_select;
    } arc_csr_s;

    // Byte address of a register index
    function automatic logic [ARC_ADDR_W-1:0] arc_addr(input logic [7:0] idx);
        arc_addr = {2'h0, idx, 2'h0};
    endfunction

endpackage

// [hw/arc_clk_div.sv]
// Purpose: Converter clock enable from the CPU clock, divide by four or two
// Assumes: One clock domain, enable is a one-cycle pulse
// Notes: Counter restarts whenever run drops so a conversion starts aligned

`timescale 1ns/1ps
`default_nettype none

module arc_clk_div
    import arc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic speed,
    // Converter clock enable
    output logic tick
);

    logic [1:0] div_reg;
    logic [1:0] top;

    // Speed bit picks the terminal count
    assign top = speed ? ARC_DIV_FAST_TOP : ARC_DIV_SLOW_TOP;
    assign tick = run && (div_reg == top);

    // Divider counter, held at zero while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
        end else if (!run || tick) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Slow rate: one tick every fourth cycle while running
    property p_div_slow;
        (tick && !speed) ##1 (run && !speed && !tick)[*3] |=> tick || !run || speed;
    endproperty
    a_div_slow: assert property (p_div_slow) else $error("slow divider period wrong");

    // Fast rate: one tick every second cycle while running
    property p_div_fast;
        (tick && speed) ##1 (run && speed) |-> !tick ##1 (!(run && speed) || tick);
    endproperty
    a_div_fast: assert property (p_div_fast) else $error("fast divider period wrong");

endmodule

`default_nettype wire

// [hw/arc_ctrl.sv]
// Purpose: Register control of a ten-bit converter behind an APB slave
// Assumes: Analog core gives a ten-bit value sampled at conversion end
// Notes: One pclk domain, converter clock is an enable from the divider
//
// The implementer's own choice: the APB slave port.

`timescale 1ns/1ps
`default_nettype none

module arc_ctrl
    import arc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ARC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor power state
    input wire logic cpu_halt,
    // Analog core
    input wire logic [9:0] analog_result,
    output logic analog_power,
    output logic [3:0] analog_channel,
    output logic analog_sample,
    // System
    output logic irq,
    output logic stabilized
);

    arc_csr_s csr_reg;
    arc_csr_s wcsr;
    logic [9:0] result_reg;
    logic [3:0] conv_cnt_reg;
    logic [ARC_IRQ_W-1:0] irq_stat_reg;
    logic [ARC_IRQ_W-1:0] irq_mask_reg;
    logic [ARC_IRQ_W-1:0] irq_clr_reg;
    logic [ARC_STAB_W-1:0] stab_cnt_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic setup_ph;
    logic access_ph;
    logic wr_csr;
    logic wr_mask;
    logic rd_drh;
    logic rd_stat;
    logic ch_change;
    logic restart;
    logic active;
    logic tick;
    logic done;
    logic abort_ev;

    // Register hit for one index
    function automatic logic arc_hit(input logic [ARC_ADDR_W-1:0] a, input logic [7:0] idx);
        arc_hit = (a == arc_addr(idx));
    endfunction

    // APB phases, slave never inserts wait states
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign wcsr = arc_csr_s'(pwdata[7:0]);

    assign wr_csr = access_ph && pwrite && arc_hit(paddr, ARC_CSR_IDX);
    assign wr_mask = access_ph && pwrite && arc_hit(paddr, ARC_IRQ_MASK_IDX);
    assign rd_drh = access_ph && !pwrite && arc_hit(paddr, ARC_DRH_IDX);
    assign rd_stat = access_ph && !pwrite && arc_hit(paddr, ARC_IRQ_STAT_IDX);

    // Read data mux, narrow registers sit in the low bits
    always_comb begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (arc_hit(paddr, ARC_CSR_IDX)) begin
            rd_mux[7:0] = csr_reg;
        end else if (arc_hit(paddr, ARC_DRH_IDX)) begin
            rd_mux[7:0] = result_reg[9:2];
        end else if (arc_hit(paddr, ARC_DRL_IDX)) begin
            rd_mux[1:0] = result_reg[1:0];
        end else if (arc_hit(paddr, ARC_IRQ_STAT_IDX)) begin
            rd_mux[ARC_IRQ_W-1:0] = irq_stat_reg;
        end else if (arc_hit(paddr, ARC_IRQ_MASK_IDX)) begin
            rd_mux[ARC_IRQ_W-1:0] = irq_mask_reg;
        end else if (arc_hit(paddr, ARC_AUX_IDX)) begin
            rd_mux[0] = stabilized;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Capture read data in setup so the answer comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
            irq_clr_reg <= ARC_IRQ_RST;
        end else if (setup_ph) begin
            prdata_reg <= pwrite ? 32'h0 : rd_mux;
            pslverr_reg <= !rd_hit;
            irq_clr_reg <= irq_stat_reg;
        end
    end

    // Wait state is not an input at all, so it cannot touch the converter
    assign active = csr_reg.conv_on && !cpu_halt;
    assign analog_power = active;
    assign analog_channel = csr_reg.channel_select;

    // A new channel or a fresh turn-on aborts and restarts the sequence
    assign ch_change = wr_csr && (wcsr.channel_select != csr_reg.channel_select);
    // Turning off also counts, so no tick or end slips through the stopping write
    assign restart = ch_change || (wr_csr && (wcsr.conv_on != csr_reg.conv_on));
    assign abort_ev = ch_change && active;

    arc_clk_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(active && !restart),
        .speed(csr_reg.speed),
        .tick(tick)
    );

    // Conversion end after the set number of converter clocks
    assign done = active && !restart && tick && (conv_cnt_reg == ARC_CONV_TICKS - 4'h1);
    assign analog_sample = done;

    // Conversion progress counter, free running while on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_reg <= 4'h0;
        end else if (!active || restart) begin
            conv_cnt_reg <= 4'h0;
        end else if (done) begin
            conv_cnt_reg <= 4'h0;
        end else if (tick) begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
        end
    end

    // Result is not latched against reads, every end overwrites it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= ARC_RESULT_RST;
        end else if (done) begin
            result_reg <= analog_result;
        end
    end

    // Control fields written by software, reserved bit kept clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_reg <= arc_csr_s'(ARC_CSR_RST);
        end else begin
            if (wr_csr) begin
                csr_reg.speed <= wcsr.speed;
                csr_reg.conv_on <= wcsr.conv_on;
                csr_reg.channel_select <= wcsr.channel_select;
            end
            csr_reg.rsvd <= 1'b0;
            // Completion beats a clear in the same cycle
            csr_reg.eoc <= done || (csr_reg.eoc && !wr_csr && !rd_drh);
        end
    end

    // Sticky events, read clears only what the read returned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= ARC_IRQ_RST;
        end else begin
            irq_stat_reg[ARC_IRQ_DONE_BIT] <= done ||
                (irq_stat_reg[ARC_IRQ_DONE_BIT] && !(rd_stat && irq_clr_reg[ARC_IRQ_DONE_BIT]));
            irq_stat_reg[ARC_IRQ_ABORT_BIT] <= abort_ev ||
                (irq_stat_reg[ARC_IRQ_ABORT_BIT] && !(rd_stat && irq_clr_reg[ARC_IRQ_ABORT_BIT]));
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= ARC_IRQ_RST;
        end else if (wr_mask) begin
            irq_mask_reg <= pwdata[ARC_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Stabilization count, held full through halt so stabilized cannot blip at wakeup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt_reg <= '0;
        end else if (cpu_halt) begin
            stab_cnt_reg <= ARC_STAB_W'(ARC_STAB_CYCLES);
        end else if (stab_cnt_reg != '0) begin
            stab_cnt_reg <= stab_cnt_reg - ARC_STAB_W'(1);
        end
    end

    assign stabilized = !cpu_halt && (stab_cnt_reg == '0);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_halt_off;
        cpu_halt |-> !analog_power && !done;
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("converter ran in halt");

    property p_stab_wait;
        $fell(cpu_halt) |-> !stabilized [*8];
    endproperty
    a_stab_wait: assert property (p_stab_wait) else $error("stabilization skipped");

    property p_off_stops;
        (wr_csr && !wcsr.conv_on) |=> !analog_power && conv_cnt_reg == 4'h0;
    endproperty
    a_off_stops: assert property (p_off_stops) else $error("converter kept running");

    property p_done_sets;
        done |=> csr_reg.eoc && irq_stat_reg[ARC_IRQ_DONE_BIT];
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done flag not set");

    property p_clear_flag;
        ((rd_drh || wr_csr) && !done) |=> !csr_reg.eoc;
    endproperty
    a_clear_flag: assert property (p_clear_flag) else $error("done flag not cleared");

    property p_flag_ro;
        (!csr_reg.eoc && wr_csr && wcsr.eoc && !done) |=> !csr_reg.eoc;
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("write set done flag");

    property p_result;
        done |=> result_reg == $past(analog_result) ##1 (done || $stable(result_reg));
    endproperty
    a_result: assert property (p_result) else $error("result not taken at end");

    property p_low_zero;
        (setup_ph && !pwrite && arc_hit(paddr, ARC_DRL_IDX)) |=>
            prdata[31:2] == 30'h0 && prdata[1:0] == $past(result_reg[1:0]);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low register read wrong");

    property p_abort;
        abort_ev |=> conv_cnt_reg == 4'h0 && !csr_reg.eoc && irq_stat_reg[ARC_IRQ_ABORT_BIT];
    endproperty
    a_abort: assert property (p_abort) else $error("channel change did not abort");

    property p_continuous;
        done ##1 (active && !wr_csr)[*8] |-> !done;
    endproperty
    a_continuous: assert property (p_continuous) else $error("conversion too short");

    // High byte answer is the result as it stood at the setup edge
    property p_drh_read;
        (setup_ph && !pwrite && arc_hit(paddr, ARC_DRH_IDX)) |=>
            prdata == {24'h0, $past(result_reg[9:2])};
    endproperty
    a_drh_read: assert property (p_drh_read) else $error("high register read wrong");

    property p_off_idle;
        !csr_reg.conv_on |-> !analog_power && !done;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("converter active while off");

    property p_on_restart;
        (wr_csr && wcsr.conv_on && !csr_reg.conv_on) |=>
            (analog_power || cpu_halt) && conv_cnt_reg == 4'h0;
    endproperty
    a_on_restart: assert property (p_on_restart) else $error("turn on did not restart");

    c_done: cover property (done ##[1:100] done);
    c_abort: cover property (abort_ev);
    c_wake: cover property ($fell(cpu_halt) ##[1:300] stabilized);
    c_read_high: cover property (csr_reg.eoc ##1 rd_drh);

endmodule

`default_nettype wire

// [verification/arc_analog_model.sv]
// Purpose: Behavioural analog core facing the converter register control
// Assumes: Powered result is a pure function of channel and a level from the bench
// Notes: Unpowered core shows the inverse of its last value, never a clean level

`timescale 1ns/1ps
`default_nettype none

module arc_analog_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the converter
    input wire logic analog_power,
    input wire logic [3:0] analog_channel,
    input wire logic analog_sample,
    // Level chosen by the bench
    input wire logic [9:0] level_base,
    // Value to the converter
    output logic [9:0] analog_result
);
    logic [9:0] level;
    logic [9:0] last_reg;

    // Each channel gives its own level so a wrong selection shows up
    assign level = level_base ^ {6'h0, analog_channel};

    // Remember the last powered value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 10'h000;
        end else if (analog_power) begin
            last_reg <= level;
        end
    end

    // Powered down the core gives nothing usable
    assign analog_result = analog_power ? level : ~last_reg;
endmodule

`default_nettype wire

// [verification/adc_register_control_test.sv]
// Purpose: Self-checking bench for the converter register control
// Assumes: Reads complete in two cycles, conversions 22 or 44 cycles apart
// Notes: Driver queues expected answers, a monitor compares at each access edge

`timescale 1ns/1ps
`default_nettype none

module adc_register_control_test;
    import arc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_halt;
    logic analog_power, analog_sample, irq, stabilized;
    logic [ARC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] analog_result, base;
    logic [3:0] analog_channel;
    logic [64:0] note_q[$];
    logic [64:0] note;
    int error_cnt = 0;
    int checks_done = 0;

    arc_ctrl u_arc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halt(cpu_halt), .analog_result(analog_result),
        .analog_power(analog_power), .analog_channel(analog_channel),
        .analog_sample(analog_sample), .irq(irq), .stabilized(stabilized));

    arc_analog_model u_arc_analog_model (.pclk(pclk), .presetn(presetn),
        .analog_power(analog_power), .analog_channel(analog_channel),
        .analog_sample(analog_sample), .level_base(base), .analog_result(analog_result));

    // Clock at 20 MHz
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, expected answer noted first; idle cycle after
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [31:0] exp, input logic [31:0] care);
        int n;
        n = 0;
        note_q.push_back({(idx < 8'h70 || idx > 8'h75), care, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] care);
        apb(1'b0, idx, 8'h00, exp, care);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, 32'h0, 32'h0);
    endtask

    // Cycles up to the next conversion end, 200 means none came
    task automatic wait_smp(output int c);
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (analog_sample !== 1'b1 && c < 200);
        @(posedge pclk);
    endtask

    // Monitor takes the oldest note at every completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            if (note_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                note = note_q.pop_front();
                chk({31'h0, pslverr}, {31'h0, note[64]});
                chk(prdata & note[63:32], note[31:0] & note[63:32]);
            end
        end
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    initial begin
        int c;
        int sp;
        logic [3:0] ch;
        logic [9:0] bv;
        logic [9:0] val;
        {psel, penable, pwrite, cpu_halt} = 4'h0;
        paddr = '0;
        pwdata = 32'h0;
        base = 10'h000;
        presetn = 1'b0;
        void'($urandom(32'hb4d2));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, read-only write, unmapped place
        rd(8'h70, 32'h0, 32'hffffffff);
        rd(8'h71, 32'h0, 32'hffffffff);
        rd(8'h72, 32'h0, 32'hffffffff);
        wr(8'h71, 8'hff);
        rd(8'h71, 32'h0, 32'hffffffff);
        rd(8'h76, 32'h0, 32'hffffffff);
        $display("test reset done");
        // Every channel code, flag and reserved bit refuse writes
        for (int i = 0; i < 16; i++) begin
            wr(8'h70, 8'h90 | i[7:0]);
            chk({28'h0, analog_channel}, i);
            rd(8'h70, {28'h0, i[3:0]}, 32'hffffffff);
        end
        $display("test channels done");
        // Both clock dividers, continuous conversion, result and flag
        wr(8'h74, 8'h01);
        for (sp = 1; sp >= 0; sp--) begin
            ch = 4'($urandom());
            bv = 10'($urandom());
            base <= bv;
            val = bv ^ {6'h0, ch};
            wr(8'h70, {1'b0, sp[0], 2'b10, ch});
            rd(8'h73, 32'h0, 32'h0);
            wait_smp(c);
            wait_smp(c);
            chk(c, (sp == 1) ? 22 : 44);
            chk({31'h0, irq}, 32'h1);
            rd(8'h70, {24'h0, 1'b1, sp[0], 2'b10, ch}, 32'hffffffff);
            rd(8'h72, {30'h0, val[1:0]}, 32'hffffffff);
            rd(8'h71, {24'h0, val[9:2]}, 32'hffffffff);
            rd(8'h70, {24'h0, 1'b0, sp[0], 2'b10, ch}, 32'hffffffff);
            rd(8'h73, 32'h1, 32'h1);
            chk({31'h0, irq}, 32'h0);
        end
        $display("test conversion done");
        // Channel change while converting
        wait_smp(c);
        ch = ch ^ 4'h5;
        wr(8'h70, {4'h2, ch});
        rd(8'h70, {24'h2, ch}, 32'hffffffff);
        rd(8'h73, 32'h2, 32'h2);
        wait_smp(c);
        val = bv ^ {6'h0, ch};
        rd(8'h71, {24'h0, val[9:2]}, 32'hffffffff);
        $display("test abort done");
        // Converter off stops conversions
        wr(8'h70, {4'h0, ch});
        chk({31'h0, analog_power}, 32'h0);
        wait_smp(c);
        chk(c, 200);
        $display("test off done");
        // Halt powers down, stabilization after wakeup
        wr(8'h70, {4'h2, ch});
        cpu_halt <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, analog_power, stabilized}, 32'h0);
        @(posedge pclk);
        cpu_halt <= 1'b0;
        repeat (190) @(posedge pclk);
        chk({30'h0, analog_power, stabilized}, 32'h2);
        repeat (20) @(posedge pclk);
        chk({31'h0, stabilized}, 32'h1);
        rd(8'h75, 32'h1, 32'h1);
        wait_smp(c);
        wait_smp(c);
        chk(c, 44);
        $display("test halt done");
        close_out();
    end
endmodule

`default_nettype wire
